// ### rtl/tape_cmd_pkg.sv
/*
  constants and types shared by the tape command decoder and its store.
  assumes a single 40 MHz core clock and byte-wide command delivery.
*/
package tape_cmd_pkg;
  localparam logic [7:0] OP_IDENTIFY    = 8'h12;
  localparam logic [7:0] OP_LOAD_UNLOAD = 8'h1b;
  localparam logic [7:0] OP_PARAM_SEL   = 8'h15;
  localparam logic [7:0] OP_UNIT_READY  = 8'h00;
  localparam logic [7:0] OP_PARAM_SENSE = 8'h1a;

  localparam logic [2:0] CDB_LAST   = 3'h5;
  localparam logic [2:0] CDB_OPCODE = 3'h0;
  localparam logic [2:0] CDB_COUNT  = 3'h4;
  localparam logic [2:0] CDB_CTRL   = 3'h5;

  localparam int BIT_LINK    = 0;
  localparam int BIT_FLAG    = 1;
  localparam int BIT_LOAD    = 0;
  localparam int BIT_RETEN   = 1;
  localparam int BIT_ENDPARK = 7;

  localparam logic [7:0] ID_BYTE0 = 8'h01;
  localparam logic [7:0] ID_BYTE1 = 8'h80;
  localparam logic [7:0] ID_BYTE2 = 8'h01;
  localparam logic [7:0] ID_BYTE3 = 8'h00;
  localparam logic [7:0] ID_BYTE4 = 8'h00;
  localparam logic [7:0] ID_LEN   = 8'h05;

  localparam logic [3:0] PLIST_MIN = 4'h4;
  localparam logic [3:0] PLIST_MAX = 4'hd;

  localparam logic [7:0] ST_GOOD  = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [7:0] ST_BUSY  = 8'h08;
  localparam logic [3:0] SK_NONE    = 4'h0;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;

  localparam int STORE_AW = 4;

  typedef enum logic [2:0] {
    S_IDLE, S_DECODE, S_DATAIN, S_DATAOUT, S_MOTION
  } cmd_state_t;
endpackage : tape_cmd_pkg

// ### rtl/param_store.sv
/*
  small byte memory holding the received parameter list.
  assumes writes and reads on the core clock; read data is registered.
*/
`timescale 1ns/1ps
module param_store
  import tape_cmd_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                wr_en,
  input  wire logic [STORE_AW-1:0] wr_addr,
  input  wire logic [7:0]          wr_data,
  input  wire logic [STORE_AW-1:0] rd_addr,
  output logic      [7:0]          rd_data_q
);
  logic [7:0] mem [2**STORE_AW];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule : param_store

// ### rtl/tape_cmd_decoder.sv
/*
  target-side interpreter for identify, load/unload and parameter select.
  assumes command, data and status phases are sequenced by outside logic
  on the same clock; cartridge_present comes from a pin.
*/
`timescale 1ns/1ps
module tape_cmd_decoder
  import tape_cmd_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                cdb_valid,
  input  wire logic [7:0]          cdb_byte,
  output logic                     data_in_valid_q,
  output logic      [7:0]          data_in_byte_q,
  input  wire logic                data_in_ready,
  output logic                     data_out_req_q,
  input  wire logic                data_out_valid,
  input  wire logic [7:0]          data_out_byte,
  output logic                     status_valid_q,
  output logic      [7:0]          status_code_q,
  output logic      [3:0]          sense_key_q,
  output logic                     link_next_q,
  output logic                     flag_irq_q,
  output logic                     other_cmd_q,
  output logic      [7:0]          other_opcode_q,
  input  wire logic                disconnect_enable,
  output logic                     stay_connected_q,
  output logic                     may_disconnect_q,
  input  wire logic                auto_load_active,
  output logic                     motion_req_q,
  output logic                     retension_request_q,
  output logic                     load_select_q,
  output logic                     end_park_select_q,
  input  wire logic                motion_done,
  input  wire logic                cartridge_present,
  input  wire logic                prevent_removal,
  output logic                     not_safe_remove_indicator_q,
  output logic      [3:0]          param_len_q,
  input  wire logic [STORE_AW-1:0] param_rd_addr,
  output logic      [7:0]          param_rd_data_q
);
  import tape_cmd_pkg::*;

  cmd_state_t    state_q;
  logic [7:0]    cdb_q [6];
  logic [2:0]    cdb_cnt_q;
  logic [7:0]    xfer_len_q;
  logic [7:0]    xfer_idx_q;
  logic          present_s1_q;
  logic          present_s2_q;
  logic          present_s3_q;
  logic          removed;
  logic          unload_done;
  logic          load_seen;
  logic          store_we;
  logic [7:0]    op;
  logic [7:0]    ctrl;
  logic [7:0]    count;

  assign op          = cdb_q[CDB_OPCODE];
  assign ctrl        = cdb_q[CDB_CTRL];
  assign count       = cdb_q[CDB_COUNT];
  assign store_we    = (state_q == S_DATAOUT) && data_out_valid;
  assign removed     = present_s3_q && !present_s2_q;
  assign unload_done = (state_q == S_MOTION) && motion_done && !load_select_q;
  assign load_seen   = (state_q == S_DECODE) && (op == OP_LOAD_UNLOAD)
                       && count[BIT_LOAD];

  function automatic logic [7:0] id_byte(input logic [7:0] idx);
    case (idx)
      8'h00:   id_byte = ID_BYTE0;
      8'h01:   id_byte = ID_BYTE1;
      8'h02:   id_byte = ID_BYTE2;
      8'h03:   id_byte = ID_BYTE3;
      default: id_byte = ID_BYTE4;
    endcase
  endfunction : id_byte

  function automatic logic plist_ok(input logic [3:0] len);
    plist_ok = (len == 4'h0) || (len >= PLIST_MIN && len <= PLIST_MAX);
  endfunction : plist_ok

  // cartridge pin synchroniser plus one stage for the edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      present_s1_q <= 1'b0;
      present_s2_q <= 1'b0;
      present_s3_q <= 1'b0;
    end else begin
      present_s1_q <= cartridge_present;
      present_s2_q <= present_s1_q;
      present_s3_q <= present_s2_q;
    end
  end

  // command block capture
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cdb_cnt_q <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        cdb_q[i] <= 8'h00;
      end
    end else if (state_q == S_IDLE && cdb_valid) begin
      cdb_q[cdb_cnt_q] <= cdb_byte;
      cdb_cnt_q <= (cdb_cnt_q == CDB_LAST) ? 3'h0 : cdb_cnt_q + 3'h1;
    end
  end

  // not-safe indicator; a new load wins over a clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      not_safe_remove_indicator_q <= 1'b0;
    end else if (load_seen) begin
      not_safe_remove_indicator_q <= 1'b1;
    end else if ((removed || unload_done) && !prevent_removal) begin
      not_safe_remove_indicator_q <= 1'b0;
    end
  end

  // main command sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q             <= S_IDLE;
      data_in_valid_q     <= 1'b0;
      data_in_byte_q      <= 8'h00;
      data_out_req_q      <= 1'b0;
      status_valid_q      <= 1'b0;
      status_code_q       <= ST_GOOD;
      sense_key_q         <= SK_NONE;
      link_next_q         <= 1'b0;
      flag_irq_q          <= 1'b0;
      other_cmd_q         <= 1'b0;
      other_opcode_q      <= 8'h00;
      stay_connected_q    <= 1'b0;
      may_disconnect_q    <= 1'b0;
      motion_req_q        <= 1'b0;
      retension_request_q <= 1'b0;
      load_select_q       <= 1'b0;
      end_park_select_q   <= 1'b0;
      param_len_q         <= 4'h0;
      xfer_len_q          <= 8'h00;
      xfer_idx_q          <= 8'h00;
    end else begin
      status_valid_q <= 1'b0;
      link_next_q    <= 1'b0;
      flag_irq_q     <= 1'b0;
      other_cmd_q    <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (cdb_valid && cdb_cnt_q == CDB_LAST) begin
            state_q <= S_DECODE;
          end
        end
        S_DECODE: begin
          xfer_idx_q  <= 8'h00;
          sense_key_q <= SK_NONE;
          if (op == OP_IDENTIFY) begin
            stay_connected_q <= 1'b1;
            xfer_len_q <= (count < ID_LEN) ? count : ID_LEN;
            if (count == 8'h00) begin
              state_q          <= S_IDLE;
              stay_connected_q <= 1'b0;
              status_valid_q   <= 1'b1;
              status_code_q    <= ST_GOOD;
              link_next_q      <= ctrl[BIT_LINK];
              flag_irq_q       <= ctrl[BIT_LINK] && ctrl[BIT_FLAG];
            end else begin
              state_q         <= S_DATAIN;
              data_in_valid_q <= 1'b1;
              data_in_byte_q  <= id_byte(8'h00);
            end
          end else if (op == OP_LOAD_UNLOAD) begin
            state_q             <= S_MOTION;
            motion_req_q        <= 1'b1;
            may_disconnect_q    <= disconnect_enable;
            retension_request_q <= count[BIT_RETEN];
            load_select_q       <= count[BIT_LOAD];
            end_park_select_q   <= !count[BIT_LOAD]
                                   && ctrl[BIT_ENDPARK];
          end else if (op == OP_PARAM_SEL) begin
            param_len_q <= count[3:0];
            if (!plist_ok(count[3:0]) || count[7:4] != 4'h0) begin
              state_q        <= S_IDLE;
              status_valid_q <= 1'b1;
              status_code_q  <= ST_CHECK;
              sense_key_q    <= SK_ILLEGAL;
            end else if (count[3:0] == 4'h0) begin
              state_q        <= S_IDLE;
              status_valid_q <= 1'b1;
              status_code_q  <= ST_GOOD;
              link_next_q    <= ctrl[BIT_LINK];
              flag_irq_q     <= ctrl[BIT_LINK] && ctrl[BIT_FLAG];
            end else begin
              state_q          <= S_DATAOUT;
              stay_connected_q <= 1'b1;
              data_out_req_q   <= 1'b1;
              xfer_len_q       <= {4'h0, count[3:0]};
            end
          end else if ((op == OP_UNIT_READY || op == OP_PARAM_SENSE)
                       && auto_load_active) begin
            state_q        <= S_IDLE;
            status_valid_q <= 1'b1;
            status_code_q  <= ST_BUSY;
          end else begin
            state_q        <= S_IDLE;
            other_cmd_q    <= 1'b1;
            other_opcode_q <= op;
          end
        end
        S_DATAIN: begin
          if (data_in_ready) begin
            if (xfer_idx_q + 8'h01 == xfer_len_q) begin
              state_q          <= S_IDLE;
              data_in_valid_q  <= 1'b0;
              stay_connected_q <= 1'b0;
              status_valid_q   <= 1'b1;
              status_code_q    <= ST_GOOD;
              link_next_q      <= ctrl[BIT_LINK];
              flag_irq_q       <= ctrl[BIT_LINK] && ctrl[BIT_FLAG];
            end else begin
              xfer_idx_q     <= xfer_idx_q + 8'h01;
              data_in_byte_q <= id_byte(xfer_idx_q + 8'h01);
            end
          end
        end
        S_DATAOUT: begin
          if (data_out_valid) begin
            if (xfer_idx_q + 8'h01 == xfer_len_q) begin
              state_q          <= S_IDLE;
              data_out_req_q   <= 1'b0;
              stay_connected_q <= 1'b0;
              status_valid_q   <= 1'b1;
              status_code_q    <= ST_GOOD;
              link_next_q      <= ctrl[BIT_LINK];
              flag_irq_q       <= ctrl[BIT_LINK] && ctrl[BIT_FLAG];
            end else begin
              xfer_idx_q <= xfer_idx_q + 8'h01;
            end
          end
        end
        S_MOTION: begin
          if (motion_done) begin
            state_q          <= S_IDLE;
            motion_req_q     <= 1'b0;
            may_disconnect_q <= 1'b0;
            status_valid_q   <= 1'b1;
            status_code_q    <= ST_GOOD;
            link_next_q      <= ctrl[BIT_LINK];
            flag_irq_q       <= ctrl[BIT_LINK] && ctrl[BIT_FLAG];
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  param_store u_store (
    .core_clk  (core_clk),
    .rst       (rst),
    .wr_en     (store_we),
    .wr_addr   (xfer_idx_q[STORE_AW-1:0]),
    .wr_data   (data_out_byte),
    .rd_addr   (param_rd_addr),
    .rd_data_q (param_rd_data_q)
  );

  sequence seq_bad_select;
    state_q == S_DECODE && op == OP_PARAM_SEL && !plist_ok(count[3:0]);
  endsequence

  sequence seq_check_illegal;
    status_valid_q && status_code_q == ST_CHECK
      && sense_key_q == SK_ILLEGAL && state_q == S_IDLE;
  endsequence

  sequence seq_identify_zero;
    state_q == S_DECODE && op == OP_IDENTIFY && count == 8'h00;
  endsequence

  AST_ID_TYPE: assert property (@(posedge core_clk) disable iff (rst)
    data_in_valid_q && xfer_idx_q == 8'h00 |-> data_in_byte_q == 8'h01)
    else $error("identify byte 0 wrong");

  AST_ID_REMOVABLE: assert property (@(posedge core_clk) disable iff (rst)
    data_in_valid_q && xfer_idx_q == 8'h01 |-> data_in_byte_q == 8'h80)
    else $error("identify byte 1 wrong");

  AST_ID_VERSION: assert property (@(posedge core_clk) disable iff (rst)
    data_in_valid_q && xfer_idx_q == 8'h02 |-> data_in_byte_q == 8'h01)
    else $error("identify byte 2 wrong");

  AST_ID_ADDLEN: assert property (@(posedge core_clk) disable iff (rst)
    data_in_valid_q && xfer_idx_q == 8'h04 |-> data_in_byte_q == 8'h00)
    else $error("identify byte 4 wrong");

  AST_INQ_LIMIT: assert property (@(posedge core_clk) disable iff (rst)
    data_in_valid_q |-> xfer_idx_q < xfer_len_q && xfer_len_q <= count)
    else $error("identify sends beyond allocation");

  AST_INQ_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    seq_identify_zero |=> status_valid_q && status_code_q == ST_GOOD
      && !data_in_valid_q)
    else $error("zero allocation mishandled");

  AST_STAY: assert property (@(posedge core_clk) disable iff (rst)
    state_q == S_DATAIN || state_q == S_DATAOUT
      |-> stay_connected_q && !may_disconnect_q)
    else $error("released bus mid command");

  AST_DISC_GATE: assert property (@(posedge core_clk) disable iff (rst)
    state_q == S_DECODE && op == OP_LOAD_UNLOAD
      |=> may_disconnect_q == $past(disconnect_enable) && motion_req_q)
    else $error("disconnect not gated by enable");

  AST_BAD_LEN: assert property (@(posedge core_clk) disable iff (rst)
    seq_bad_select |=> seq_check_illegal ##1 !status_valid_q)
    else $error("bad length not refused");

  AST_LINK: assert property (@(posedge core_clk) disable iff (rst)
    link_next_q |-> status_valid_q && status_code_q == ST_GOOD)
    else $error("link without good status");

  AST_FLAG: assert property (@(posedge core_clk) disable iff (rst)
    flag_irq_q |-> link_next_q && ctrl[BIT_FLAG])
    else $error("flag interrupt without link");

  AST_BUSY: assert property (@(posedge core_clk) disable iff (rst)
    state_q == S_DECODE && op == OP_PARAM_SENSE && auto_load_active
      |=> status_valid_q && status_code_q == ST_BUSY)
    else $error("no busy during auto load");

  AST_LOAD_LAMP: assert property (@(posedge core_clk) disable iff (rst)
    load_seen |=> not_safe_remove_indicator_q [*2])
    else $error("load did not light indicator");
endmodule : tape_cmd_decoder

// ### verif/initiator_model.sv
/*
  initiator model: takes identify bytes, supplies parameter bytes.
  assumes the decoder on the same core clock; drives at falling edge.
*/
`timescale 1ns/1ps
module initiator_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        clr,
  input  wire logic [3:0]  plen,
  input  wire logic        data_in_valid_q,
  input  wire logic [7:0]  data_in_byte_q,
  output logic             data_in_ready,
  input  wire logic        data_out_req_q,
  output logic             data_out_valid,
  output logic [7:0]       data_out_byte,
  output logic [39:0]      got_bytes,
  output logic [3:0]       got_count
);
  logic [3:0] sent;
  logic       go;
  initial begin
    data_in_ready = 1'b0;
    data_out_valid = 1'b0;
    data_out_byte = 8'h00;
  end
  // ready stalls every other cycle when slow
  always @(negedge core_clk) begin
    data_in_ready <= !rst && (slow ? !data_in_ready : 1'b1);
  end
  // exactly plen bytes, released line shows inverse
  always @(negedge core_clk) begin
    go = data_out_req_q && sent < plen && !(slow && data_out_valid);
    data_out_valid <= go;
    data_out_byte <= go ? 8'ha0 + {4'h0, sent} : ~data_out_byte;
  end
  always @(posedge core_clk or posedge rst) begin
    if (rst || !data_out_req_q) begin
      sent <= 4'h0;
    end else if (data_out_valid) begin
      sent <= sent + 4'h1;
    end
  end
  always @(posedge core_clk or posedge rst) begin
    if (rst || clr) begin
      got_bytes <= 40'h0;
      got_count <= 4'h0;
    end else if (data_in_valid_q && data_in_ready) begin
      got_bytes <= {got_bytes[31:0], data_in_byte_q};
      got_count <= got_count + 4'h1;
    end
  end
endmodule : initiator_model

// ### verif/scsi_tape_cmd_decoder_tb.sv
/*
  self-checking bench for the tape command decoder.
  assumes initiator_model on the data phases; inputs change at falling edge.
*/
`timescale 1ns/1ps
module scsi_tape_cmd_decoder_tb import tape_cmd_pkg::*;;
  logic                core_clk, rst, cdb_valid, data_in_ready;
  logic [7:0]          cdb_byte, data_in_byte_q, data_out_byte;
  logic                data_in_valid_q, data_out_req_q, data_out_valid;
  logic                status_valid_q, link_next_q, flag_irq_q;
  logic [7:0]          status_code_q, other_opcode_q, param_rd_data_q;
  logic [3:0]          sense_key_q, param_len_q, plen, got_count;
  logic                other_cmd_q, disconnect_enable, stay_connected_q;
  logic                may_disconnect_q, auto_load_active, motion_req_q;
  logic                retension_request_q, load_select_q;
  logic                end_park_select_q, motion_done, cartridge_present;
  logic                prevent_removal, not_safe_remove_indicator_q;
  logic [STORE_AW-1:0] param_rd_addr;
  logic                slow, clr, ok;
  logic [39:0]         got_bytes;
  logic [7:0]          plist [0:5] = '{8'h00, 8'h04, 8'h0d, 8'h03,
                                       8'h0e, 8'h14};
  int                  miscompares = 0;
  int                  cmp_count = 0;

  tape_cmd_decoder dut_u (.core_clk(core_clk), .rst(rst),
    .cdb_valid(cdb_valid), .cdb_byte(cdb_byte),
    .data_in_valid_q(data_in_valid_q), .data_in_byte_q(data_in_byte_q),
    .data_in_ready(data_in_ready), .data_out_req_q(data_out_req_q),
    .data_out_valid(data_out_valid), .data_out_byte(data_out_byte),
    .status_valid_q(status_valid_q), .status_code_q(status_code_q),
    .sense_key_q(sense_key_q), .link_next_q(link_next_q),
    .flag_irq_q(flag_irq_q), .other_cmd_q(other_cmd_q),
    .other_opcode_q(other_opcode_q), .disconnect_enable(disconnect_enable),
    .stay_connected_q(stay_connected_q), .may_disconnect_q(may_disconnect_q),
    .auto_load_active(auto_load_active), .motion_req_q(motion_req_q),
    .retension_request_q(retension_request_q),
    .load_select_q(load_select_q), .end_park_select_q(end_park_select_q),
    .motion_done(motion_done), .cartridge_present(cartridge_present),
    .prevent_removal(prevent_removal),
    .not_safe_remove_indicator_q(not_safe_remove_indicator_q),
    .param_len_q(param_len_q), .param_rd_addr(param_rd_addr),
    .param_rd_data_q(param_rd_data_q));

  initiator_model initiator_u (.core_clk(core_clk), .rst(rst), .slow(slow),
    .clr(clr), .plen(plen), .data_in_valid_q(data_in_valid_q),
    .data_in_byte_q(data_in_byte_q), .data_in_ready(data_in_ready),
    .data_out_req_q(data_out_req_q), .data_out_valid(data_out_valid),
    .data_out_byte(data_out_byte), .got_bytes(got_bytes),
    .got_count(got_count));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send_cdb(input logic [7:0] op, b4, b5);
    logic [7:0] cdb [0:5];
    cdb = '{op, 8'h00, 8'h00, 8'h00, b4, b5};
    for (int i = 0; i < 6; i++) begin
      @(negedge core_clk);
      cdb_valid = 1'b1;
      cdb_byte = cdb[i];
      clr = (i == 0);
    end
    @(negedge core_clk);
    cdb_valid = 1'b0;
    clr = 1'b0;
  endtask : send_cdb

  // bounded wait for status pulse, or other-command pulse
  task automatic wait_evt(input bit oth);
    int n;
    for (n = 0; n < 400; n++) begin
      if ((oth ? other_cmd_q : status_valid_q) === 1'b1) break;
      @(negedge core_clk);
    end
    if (n == 400) begin
      miscompares++;
      $display("unexpected at %0t: no completion", $time);
      give_verdict();
    end
  endtask : wait_evt

  task automatic fin(input logic [7:0] st, input logic lk, fl);
    wait_evt(1'b0);
    check({status_code_q, link_next_q, flag_irq_q}, {st, lk, fl});
  endtask : fin

  task automatic motion_end;
    @(negedge core_clk);
    motion_done = 1'b1;
    @(negedge core_clk);
    motion_done = 1'b0;
    fin(ST_GOOD, 1'b0, 1'b0);
  endtask : motion_end

  initial begin
    {rst, slow, cartridge_present} = 3'b101;
    {cdb_valid, clr, disconnect_enable, auto_load_active} = 4'h0;
    {motion_done, prevent_removal} = 2'b00;
    {cdb_byte, plen, param_rd_addr} = 16'h0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    check(not_safe_remove_indicator_q, 1'b0);
    send_cdb(OP_IDENTIFY, 8'h00, 8'h00);
    fin(ST_GOOD, 1'b0, 1'b0);
    check(got_count, 4'h0);
    slow = 1'b1;
    send_cdb(OP_IDENTIFY, 8'h03, 8'h03);
    repeat (2) @(negedge core_clk);
    check(stay_connected_q, 1'b1);
    fin(ST_GOOD, 1'b1, 1'b1);
    check(got_bytes[23:0], 24'h018001);
    check(got_count, 4'h3);
    slow = 1'b0;
    send_cdb(OP_IDENTIFY, 8'h09, 8'h02);
    fin(ST_GOOD, 1'b0, 1'b0);
    check(got_bytes, 40'h0180010000);
    check(got_count, 4'h5);
    foreach (plist[k]) begin
      ok = plist[k] == 8'h00 || (plist[k] >= 8'h04 && plist[k] <= 8'h0d);
      slow = k[0];
      plen = ok ? plist[k][3:0] : 4'h0;
      send_cdb(OP_PARAM_SEL, plist[k], 8'h01);
      fin(ok ? ST_GOOD : ST_CHECK, ok, 1'b0);
      check(sense_key_q, ok ? SK_NONE : SK_ILLEGAL);
      check(param_len_q, plist[k][3:0]);
      check(data_out_req_q, 1'b0);
      if (ok && plist[k] != 8'h00) begin
        param_rd_addr = plist[k][3:0] - 4'h1;
        repeat (2) @(negedge core_clk);
        check(param_rd_data_q, 8'h9f + plist[k]);
      end
    end
    auto_load_active = 1'b1;
    send_cdb(OP_UNIT_READY, 8'h00, 8'h00);
    fin(ST_BUSY, 1'b0, 1'b0);
    send_cdb(OP_PARAM_SENSE, 8'h00, 8'h00);
    fin(ST_BUSY, 1'b0, 1'b0);
    auto_load_active = 1'b0;
    send_cdb(OP_UNIT_READY, 8'h00, 8'h00);
    wait_evt(1'b1);
    check(other_opcode_q, OP_UNIT_READY);
    disconnect_enable = 1'b1;
    send_cdb(OP_LOAD_UNLOAD, 8'h03, 8'h80);
    repeat (2) @(negedge core_clk);
    check({motion_req_q, may_disconnect_q, retension_request_q,
      load_select_q, end_park_select_q}, 5'b11110);
    check(not_safe_remove_indicator_q, 1'b1);
    motion_end();
    check(motion_req_q, 1'b0);
    disconnect_enable = 1'b0;
    send_cdb(OP_LOAD_UNLOAD, 8'h00, 8'h80);
    repeat (2) @(negedge core_clk);
    check({motion_req_q, may_disconnect_q, retension_request_q,
      load_select_q, end_park_select_q}, 5'b10001);
    check(not_safe_remove_indicator_q, 1'b1);
    motion_end();
    @(negedge core_clk);
    check(not_safe_remove_indicator_q, 1'b0);
    send_cdb(OP_LOAD_UNLOAD, 8'h01, 8'h00);
    motion_end();
    prevent_removal = 1'b1;
    cartridge_present = 1'b0;
    repeat (6) @(negedge core_clk);
    check(not_safe_remove_indicator_q, 1'b1);
    prevent_removal = 1'b0;
    cartridge_present = 1'b1;
    repeat (4) @(negedge core_clk);
    cartridge_present = 1'b0;
    repeat (6) @(negedge core_clk);
    check(not_safe_remove_indicator_q, 1'b0);
    give_verdict();
  end
endmodule : scsi_tape_cmd_decoder_tb
